// ===== verilog/ipf_pkg.sv
package ipf_pkg;

    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 32;
    localparam int          WORD_W        = 16;
    localparam int          CACHE_INDEX_W = 6;

    // Operand and transfer sizes in bytes
    localparam logic [2:0]  SIZE_BYTE     = 3'h1;
    localparam logic [2:0]  SIZE_WORD     = 3'h2;
    localparam logic [2:0]  SIZE_LONG     = 3'h4;

    // Port width reported by memory
    localparam logic [1:0]  PORT_32       = 2'h0;
    localparam logic [1:0]  PORT_8        = 2'h1;
    localparam logic [1:0]  PORT_16       = 2'h2;

    localparam logic [1:0]  LONG_ALIGN    = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOOK = 2'h1,
        ST_BUS  = 2'h3,
        ST_REL  = 2'h2
    } ipf_state_t;

endpackage

// ===== verilog/ipf_cache_mem.sv
`timescale 1ns/10ps
module ipf_cache_mem #(
    parameter int INDEX_W = ipf_pkg::CACHE_INDEX_W,
    parameter int ENTRY_W = 56
) (
    // Clock
    input  wire logic               clock,
    input  wire logic               clk_en,
    // Read port
    input  wire logic               rd_en,
    input  wire logic [INDEX_W-1:0] rd_index,
    output logic      [ENTRY_W-1:0] rd_data,
    // Write port
    input  wire logic               wr_en,
    input  wire logic [INDEX_W-1:0] wr_index,
    input  wire logic [ENTRY_W-1:0] wr_data
);

    logic [ENTRY_W-1:0] mem [2**INDEX_W];

    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_index] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= mem[rd_index];
            end
        end
    end

endmodule // ipf_cache_mem

// ===== verilog/ipf_prefetch_seq.sv
`timescale 1ns/10ps
// Behaviour
// - Cache holds instructions only; operand cycles never look up or fill it.
// - Cache hit answers the prefetch at once, with no external bus cycle.
// - Cache miss starts an external read, overlapping internal execution.
// - Next instruction can be fetched while execution is busy with current.
// - Every external instruction prefetch is a long-word read.
// - Aligned prefetch returns both words of the long word.
// - Buffered second word serves the next prefetch without a bus cycle.
// - Odd-word prefetch also reads even word; first on narrow ports.
// - Misaligned operands are split into consecutive bus cycles automatically.
// - Request arriving while bus busy is queued and run afterwards.
module ipf_prefetch_seq #(
    parameter int INDEX_W = ipf_pkg::CACHE_INDEX_W
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Control
    input  wire logic        cache_enable,
    input  wire logic        flow_change,
    // Instruction fetch
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ready,
    output logic             fetch_valid,
    output logic [15:0]      fetch_word,
    // Operand access
    input  wire logic        op_req,
    input  wire logic        op_write,
    input  wire logic [31:0] op_addr,
    input  wire logic [2:0]  op_size,
    input  wire logic [31:0] op_wdata,
    output logic             op_ready,
    output logic             op_done,
    output logic [31:0]      op_rdata,
    // External bus
    output logic             bus_req,
    output logic             bus_write,
    output logic [31:0]      bus_addr,
    output logic [2:0]       bus_size,
    output logic [31:0]      bus_wdata,
    input  wire logic        bus_ack,
    input  wire logic [1:0]  bus_width,
    input  wire logic [31:0] bus_rdata
);

    localparam int TAG_W   = 30 - INDEX_W;
    localparam int ENTRY_W = TAG_W + 32;

    typedef struct packed {
        logic                   ack_s1;
        logic                   ack_s2;
        logic [31:0]            rdata_s1;
        logic [31:0]            rdata_s2;
        logic [1:0]             width_s1;
        logic [1:0]             width_s2;
        ipf_pkg::ipf_state_t    state;
        logic                   fq_v;
        logic [31:0]            fq_addr;
        logic                   oq_v;
        logic                   oq_wr;
        logic [31:0]            oq_addr;
        logic [2:0]             oq_size;
        logic [31:0]            oq_wdata;
        logic                   is_fetch;
        logic                   fill;
        logic [31:0]            f_addr;
        logic [31:0]            base;
        logic [31:0]            cur;
        logic [2:0]             rem;
        logic [2:0]             nbytes;
        logic                   wr;
        logic [31:0]            wdata;
        logic [31:0]            acc;
        logic                   buf_v;
        logic [31:0]            buf_addr;
        logic [15:0]            buf_word;
        logic [2**INDEX_W-1:0]  valid;
        logic                   fetch_ready;
        logic                   fetch_valid;
        logic [15:0]            fetch_word;
        logic                   op_ready;
        logic                   op_done;
        logic [31:0]            op_rdata;
        logic                   bus_req;
        logic                   bus_write;
        logic [31:0]            bus_addr;
        logic [2:0]             bus_size;
        logic [31:0]            bus_wdata;
    } ipf_regs_t;

    ipf_regs_t q;
    ipf_regs_t d;

    logic [1:0]             rst_sync_q;
    logic                   mem_rd_en;
    logic [INDEX_W-1:0]     mem_rd_index;
    logic [ENTRY_W-1:0]     mem_rd_data;
    logic                   mem_wr_en;
    logic [ENTRY_W-1:0]     mem_wr_data;

    // Bytes moved in one bus cycle: never past the port or long-word boundary
    function automatic logic [2:0] xfer_len(input logic [1:0] off, input logic [2:0] rem,
                                            input logic [1:0] width);
        logic [2:0] pw;
        logic [2:0] room;
        pw = (width == ipf_pkg::PORT_8) ? ipf_pkg::SIZE_BYTE :
             (width == ipf_pkg::PORT_16) ? ipf_pkg::SIZE_WORD : ipf_pkg::SIZE_LONG;
        room = pw - ({1'b0, off} & (pw - 3'h1));
        return (rem < room) ? rem : room;
    endfunction

    // Lane l of the cycle at cur: is it moved, and which operand byte (from lsb)
    function automatic logic [2:0] lane_pos(input logic [1:0] l, input logic [31:0] cur,
                                            input logic [2:0] k, input logic [31:0] base,
                                            input logic [2:0] n);
        logic [31:0] x;
        logic [2:0]  i;
        logic        hit;
        logic [2:0]  pos;
        x   = {cur[31:2], l};
        i   = 3'(x - base);
        hit = ({1'b0, l} >= {1'b0, cur[1:0]}) && ({1'b0, l} < ({1'b0, cur[1:0]} + k));
        pos = n - 3'h1 - i;
        return {hit, pos[1:0]};
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        return a[31:INDEX_W+2];
    endfunction

    function automatic logic [INDEX_W-1:0] index_of(input logic [31:0] a);
        return a[INDEX_W+1:2];
    endfunction

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    ipf_cache_mem #(
        .INDEX_W (INDEX_W),
        .ENTRY_W (ENTRY_W)
    ) u_cache (
        .clock    (clock),
        .clk_en   (clk_en),
        .rd_en    (mem_rd_en),
        .rd_index (mem_rd_index),
        .rd_data  (mem_rd_data),
        .wr_en    (mem_wr_en),
        .wr_index (index_of(q.f_addr)),
        .wr_data  (mem_wr_data)
    );

    always_comb begin
        logic        launch;
        logic        hit;
        logic [2:0]  k;
        logic [2:0]  lp;
        logic [31:0] word_src;
        d            = q;
        launch       = 1'b0;
        hit          = 1'b0;
        k            = 3'h0;
        lp           = 3'h0;
        word_src     = 32'h0;
        mem_rd_en    = 1'b0;
        mem_rd_index = index_of(q.fq_addr);
        mem_wr_en    = 1'b0;
        mem_wr_data  = {tag_of(q.f_addr), q.acc};
        d.fetch_valid = 1'b0;
        d.op_done     = 1'b0;
        // Pins from the memory side pass two flops
        d.ack_s1   = bus_ack;
        d.ack_s2   = q.ack_s1;
        d.rdata_s1 = bus_rdata;
        d.rdata_s2 = q.rdata_s1;
        d.width_s1 = bus_width;
        d.width_s2 = q.width_s1;
        // One-deep queues so the caller runs on while the bus is busy
        if (fetch_req && q.fetch_ready) begin
            d.fq_v    = 1'b1;
            d.fq_addr = fetch_addr;
        end
        if (op_req && q.op_ready) begin
            d.oq_v     = 1'b1;
            d.oq_wr    = op_write;
            d.oq_addr  = op_addr;
            d.oq_size  = op_size;
            d.oq_wdata = op_wdata;
        end
        case (q.state)
            ipf_pkg::ST_IDLE: begin
                // Operands first: execution is stalled on them
                if (q.oq_v) begin
                    d.oq_v     = 1'b0;
                    d.is_fetch = 1'b0;
                    d.fill     = 1'b0;
                    d.base     = q.oq_addr;
                    d.cur      = q.oq_addr;
                    d.rem      = q.oq_size;
                    d.nbytes   = q.oq_size;
                    d.wr       = q.oq_wr;
                    d.wdata    = q.oq_wdata;
                    d.acc      = 32'h0;
                    launch     = 1'b1;
                end else if (q.fq_v) begin
                    d.fq_v   = 1'b0;
                    d.f_addr = q.fq_addr;
                    if (q.buf_v && q.buf_addr == q.fq_addr) begin
                        d.fetch_valid = 1'b1;
                        d.fetch_word  = q.buf_word;
                        d.buf_v       = 1'b0;
                    end else if (cache_enable) begin
                        mem_rd_en = 1'b1;
                        d.state   = ipf_pkg::ST_LOOK;
                    end else begin
                        d.is_fetch = 1'b1;
                        d.fill     = 1'b0;
                        d.base     = {q.fq_addr[31:2], ipf_pkg::LONG_ALIGN};
                        d.cur      = {q.fq_addr[31:2], ipf_pkg::LONG_ALIGN};
                        d.rem      = ipf_pkg::SIZE_LONG;
                        d.nbytes   = ipf_pkg::SIZE_LONG;
                        d.wr       = 1'b0;
                        d.acc      = 32'h0;
                        launch     = 1'b1;
                    end
                end
            end
            ipf_pkg::ST_LOOK: begin
                hit = q.valid[index_of(q.f_addr)] &&
                      mem_rd_data[ENTRY_W-1:32] == tag_of(q.f_addr);
                if (hit) begin
                    word_src      = mem_rd_data[31:0];
                    d.fetch_valid = 1'b1;
                    d.fetch_word  = q.f_addr[1] ? word_src[15:0] : word_src[31:16];
                    d.buf_v       = !q.f_addr[1];
                    d.buf_addr    = {q.f_addr[31:2], 2'h2};
                    d.buf_word    = word_src[15:0];
                    d.state       = ipf_pkg::ST_IDLE;
                end else begin
                    d.is_fetch = 1'b1;
                    d.fill     = 1'b1;
                    d.base     = {q.f_addr[31:2], ipf_pkg::LONG_ALIGN};
                    d.cur      = {q.f_addr[31:2], ipf_pkg::LONG_ALIGN};
                    d.rem      = ipf_pkg::SIZE_LONG;
                    d.nbytes   = ipf_pkg::SIZE_LONG;
                    d.wr       = 1'b0;
                    d.acc      = 32'h0;
                    launch     = 1'b1;
                end
            end
            ipf_pkg::ST_BUS: begin
                if (q.ack_s2) begin
                    for (int l = 0; l < 4; l++) begin
                        lp = lane_pos(2'(l), q.cur, q.bus_size, q.base, q.nbytes);
                        if (lp[2]) begin
                            d.acc[lp[1:0]*8 +: 8] = q.rdata_s2[(3-l)*8 +: 8];
                        end
                    end
                    d.bus_req = 1'b0;
                    d.cur     = q.cur + 32'(q.bus_size);
                    d.rem     = q.rem - q.bus_size;
                    d.state   = ipf_pkg::ST_REL;
                end
            end
            ipf_pkg::ST_REL: begin
                if (!q.ack_s2) begin
                    if (q.rem != 3'h0) begin
                        launch = 1'b1;
                    end else begin
                        d.state = ipf_pkg::ST_IDLE;
                        if (q.is_fetch) begin
                            d.fetch_valid = 1'b1;
                            d.fetch_word  = q.f_addr[1] ? q.acc[15:0] : q.acc[31:16];
                            d.buf_v       = !q.f_addr[1];
                            d.buf_addr    = {q.f_addr[31:2], 2'h2};
                            d.buf_word    = q.acc[15:0];
                            if (q.fill && cache_enable) begin
                                mem_wr_en                  = 1'b1;
                                d.valid[index_of(q.f_addr)] = 1'b1;
                            end
                        end else begin
                            d.op_done  = 1'b1;
                            d.op_rdata = q.wr ? q.op_rdata : q.acc;
                        end
                    end
                end
            end
            default: begin
                d.state = ipf_pkg::ST_IDLE;
            end
        endcase
        if (launch) begin
            k           = xfer_len(d.cur[1:0], d.rem, q.width_s2);
            d.bus_req   = 1'b1;
            d.bus_write = d.wr;
            d.bus_addr  = d.cur;
            d.bus_size  = k;
            d.bus_wdata = 32'h0;
            for (int l = 0; l < 4; l++) begin
                lp = lane_pos(2'(l), d.cur, k, d.base, d.nbytes);
                if (lp[2] && d.wr) begin
                    d.bus_wdata[(3-l)*8 +: 8] = d.wdata[lp[1:0]*8 +: 8];
                end
            end
            d.state = ipf_pkg::ST_BUS;
        end
        // Stale buffered word after a branch must never issue; flush beats a refill
        if (flow_change) begin
            d.buf_v = 1'b0;
        end
        d.fetch_ready = !d.fq_v;
        d.op_ready    = !d.oq_v;
    end

    always_ff @(posedge clock or negedge rst_sync_q[1]) begin
        if (!rst_sync_q[1]) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign fetch_ready = q.fetch_ready;
    assign fetch_valid = q.fetch_valid;
    assign fetch_word  = q.fetch_word;
    assign op_ready    = q.op_ready;
    assign op_done     = q.op_done;
    assign op_rdata    = q.op_rdata;
    assign bus_req     = q.bus_req;
    assign bus_write   = q.bus_write;
    assign bus_addr    = q.bus_addr;
    assign bus_size    = q.bus_size;
    assign bus_wdata   = q.bus_wdata;

endmodule // ipf_prefetch_seq

// ===== dv/ipf_prefetch_seq_sva.sv
`timescale 1ns/10ps
module ipf_prefetch_seq_sva #(
    parameter int INDEX_W = 6
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Requests
    input wire logic        cache_enable,
    input wire logic        op_req,
    input wire logic        op_write,
    input wire logic        op_ready,
    input wire logic        op_done,
    input wire logic        fetch_valid,
    // External bus
    input wire logic        bus_req,
    input wire logic        bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [2:0]  bus_size,
    input wire logic        bus_ack,
    input wire logic [1:0]  bus_width
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Operand outstanding: bus cycles then may belong to it
    logic op_busy_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            op_busy_q <= 1'b0;
        end else if (op_req && op_ready) begin
            op_busy_q <= 1'b1;
        end else if (op_done) begin
            op_busy_q <= 1'b0;
        end
    end

    a_fetch_long: assert property ($rose(bus_req) && !bus_write && !op_busy_q
        && bus_width == ipf_pkg::PORT_32 |-> bus_size == ipf_pkg::SIZE_LONG
        && bus_addr[1:0] == ipf_pkg::LONG_ALIGN) else $error("fetch not a long read");
    a_no_cross: assert property (bus_req |-> ({1'b0, bus_addr[1:0]} + bus_size) <= 3'h4)
        else $error("bus cycle crosses long word");
    a_port_byte: assert property (bus_req && bus_width == ipf_pkg::PORT_8
        |-> bus_size == ipf_pkg::SIZE_BYTE) else $error("too wide for byte port");
    a_port_half: assert property (bus_req && bus_width == ipf_pkg::PORT_16
        |-> ({2'h0, bus_addr[0]} + bus_size) <= 3'h2) else $error("too wide for half port");
    a_req_stable: assert property (bus_req && $past(bus_req) |-> $stable(bus_addr)
        && $stable(bus_size) && $stable(bus_write)) else $error("bus cycle changed");
    a_hold_ack: assert property ($fell(bus_req) |-> $past(bus_ack, 2))
        else $error("request dropped before ack");
    a_launch_idle: assert property ($rose(bus_req) |-> !$past(bus_ack))
        else $error("launch before previous cycle ended");
    a_op_uncached: assert property (op_req && op_ready && !op_write
        |-> ##[1:200] $rose(bus_req) && !bus_write) else $error("operand read off the bus");
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("op_done longer than a cycle");

    c_byte_port: cover property ($rose(bus_req) && bus_width == ipf_pkg::PORT_8);
    c_write_done: cover property (op_done && op_write);
    c_cached_fetch: cover property (fetch_valid && cache_enable);
endmodule // ipf_prefetch_seq_sva

bind ipf_prefetch_seq ipf_prefetch_seq_sva #(.INDEX_W(INDEX_W)) ipf_prefetch_seq_sva_inst (.*);

// ===== dv/ipf_mem_model.sv
`timescale 1ns/10ps
module ipf_mem_model (
    // Clock and wait states
    input  wire logic        clock,
    input  wire logic [1:0]  lat,
    // External bus
    input  wire logic        bus_req,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_addr,
    input  wire logic [2:0]  bus_size,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_ack,
    output logic [31:0]      bus_rdata
);
    logic [7:0] mem [logic [31:0]];

    function automatic logic [7:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    initial begin
        logic [31:0] d;
        int          k;
        bus_ack = 1'b0;
        bus_rdata = 32'h0;
        forever begin
            @(posedge clock);
            if (bus_req) begin
                repeat (lat) @(posedge clock);
                for (k = 0; k < 4; k++) begin
                    if (bus_write && k >= bus_addr[1:0] && k < bus_addr[1:0] + bus_size) begin
                        mem[{bus_addr[31:2], 2'h0} + k] = bus_wdata[31-8*k -: 8];
                    end
                    d[31-8*k -: 8] = rd({bus_addr[31:2], 2'h0} + k);
                end
                bus_ack <= 1'b1;
                bus_rdata <= d;
                while (bus_req) @(posedge clock);
                bus_ack <= 1'b0;
                // Released lanes must not keep the last value
                bus_rdata <= ~d;
            end
        end
    end
endmodule // ipf_mem_model

// ===== dv/tb_ipf_prefetch_seq.sv
`timescale 1ns/10ps
module tb_ipf_prefetch_seq;
    logic        clock = 1'b0, reset_n = 1'b0, cache_enable = 1'b0, flow_change = 1'b0;
    logic        fetch_req = 1'b0, op_req = 1'b0, op_write = 1'b0, ovr = 1'b0;
    logic [31:0] fetch_addr = 32'h0, op_addr = 32'h0, op_wdata = 32'h0;
    logic [2:0]  op_size = 3'h4;
    logic [1:0]  bus_width = 2'h0, lat = 2'h0;
    logic        fetch_ready, fetch_valid, op_ready, op_done, bus_req, bus_write, bus_ack;
    logic [15:0] fetch_word, old;
    logic [31:0] op_rdata, bus_addr, bus_wdata, bus_rdata;
    logic [2:0]  bus_size;
    int          num_errors = 0, n_checks = 0, nbus = 0, seed = 92870;

    always #5 clock = ~clock;
    always @(posedge bus_req) nbus++;

    ipf_prefetch_seq #(.INDEX_W(2)) ipf_prefetch_seq_inst (
        .clock(clock), .reset_n(reset_n), .clk_en(1'b1),
        .cache_enable(cache_enable), .flow_change(flow_change),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .op_req(op_req), .op_write(op_write), .op_addr(op_addr), .op_size(op_size),
        .op_wdata(op_wdata), .op_ready(op_ready), .op_done(op_done), .op_rdata(op_rdata),
        .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
        .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_width(bus_width), .bus_rdata(bus_rdata)
    );
    ipf_mem_model ipf_mem_model_inst (
        .clock(clock), .lat(lat), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [15:0] word_at(input logic [31:0] a);
        return {ipf_mem_model_inst.rd(a), ipf_mem_model_inst.rd(a + 1)};
    endfunction

    task automatic flush;
        flow_change <= 1'b1;
        @(posedge clock);
        flow_change <= 1'b0;
        @(posedge clock);
    endtask

    task automatic fetch(input logic [31:0] a, input bit hit);
        int          n0, w;
        logic [15:0] e;
        e = ovr ? old : word_at(a);
        n0 = nbus;
        for (w = 0; w < 500 && fetch_ready !== 1'b1; w++) @(posedge clock);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(posedge clock);
        fetch_req <= 1'b0;
        for (w = 0; w < 500 && fetch_valid !== 1'b1; w++) @(posedge clock);
        chk(32'(w < 500), 32'h1);
        chk(32'(fetch_word), 32'(e));
        if (hit) begin
            chk(32'(nbus - n0), 32'h0);
            chk(32'(w < 6), 32'h1);
        end else begin
            chk(32'(nbus > n0), 32'h1);
        end
    endtask

    task automatic op(input bit wr, input logic [31:0] a, input logic [2:0] n,
                      input logic [31:0] d, output logic [31:0] q);
        int w;
        for (w = 0; w < 500 && op_ready !== 1'b1; w++) @(posedge clock);
        op_req <= 1'b1;
        op_write <= wr;
        op_addr <= a;
        op_size <= n;
        op_wdata <= d;
        @(posedge clock);
        op_req <= 1'b0;
        for (w = 0; w < 500 && op_done !== 1'b1; w++) @(posedge clock);
        chk(32'(w < 500), 32'h1);
        @(posedge clock);
        q = op_rdata;
    endtask

    task automatic rw(input logic [31:0] a, input logic [2:0] n);
        logic [31:0] d, m, e, q;
        int          i;
        d = $random(seed);
        m = (n == 3'h4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
        op(1'b1, a, n, d, q);
        e = 32'h0;
        for (i = 0; i < n; i++) e = {e[23:0], ipf_mem_model_inst.rd(a + i)};
        chk(e, d & m);
        op(1'b0, a, n, 32'h0, q);
        chk(q & m, d & m);
    endtask

    initial begin
        logic [31:0] q;
        int          i;
        repeat (8) @(posedge clock);
        chk(32'(bus_req), 32'h0);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        fetch(32'h200, 1'b0);
        fetch(32'h202, 1'b1);
        fetch(32'h20a, 1'b0);
        fetch(32'h20c, 1'b0);
        flush;
        fetch(32'h20e, 1'b0);
        cache_enable <= 1'b1;
        fetch(32'h300, 1'b0);
        flush;
        fetch(32'h300, 1'b1);
        fetch(32'h302, 1'b1);
        old = word_at(32'h300);
        rw(32'h300, 3'h4);
        flush;
        // Bench-only flag: must be seen by the very next expectation
        ovr = 1'b1;
        fetch(32'h300, 1'b1);
        ovr = 1'b0;
        op(1'b0, 32'h340, 3'h4, 32'h0, q);
        flush;
        fetch(32'h340, 1'b0);
        fork
            fetch(32'h400, 1'b0);
            rw(32'h404, 3'h4);
        join
        for (i = 0; i < 60; i++) begin
            if (i % 20 == 0) begin
                bus_width <= 2'(i / 20);
                repeat (4) @(posedge clock);
                flush;
                fetch(32'h502 + 32'(16 * i), 1'b0);
                rw(32'h603, 3'h4);
                rw(32'h607, 3'h2);
            end
            lat <= 2'($random(seed));
            rw(32'h600 + 32'($random(seed) & 32'h3f), 3'h1 << (i % 3));
        end
        results();
    end

    initial begin
        #500000;
        num_errors++;
        results();
    end
endmodule // tb_ipf_prefetch_seq
